// ### aidr_params.svh
// Offsets, field positions and constants of the diagnostic record block
`ifndef AIDR_PARAMS_SVH
`define AIDR_PARAMS_SVH
`define AIDR_CLK_MHZ 20
`define AIDR_TICK_US 1
`define AIDR_TICK_CYC (`AIDR_CLK_MHZ * `AIDR_TICK_US)
`define AIDR_TICK_W 32
// Input area byte offsets
`define AIDR_IN_CH0 3'h0
`define AIDR_IN_CH1 3'h2
`define AIDR_IN_CH2 3'h4
`define AIDR_IN_CH3 3'h6
// Diagnostic record byte offsets
`define AIDR_DG_SUMMARY 5'h00
`define AIDR_DG_MODINFO 5'h01
`define AIDR_DG_RSVD_C 5'h02
`define AIDR_DG_INTERNAL 5'h03
`define AIDR_DG_CHKIND 5'h04
`define AIDR_DG_DIAG_BITS_PER_CHANNEL 5'h05
`define AIDR_DG_CHANNEL_COUNT 5'h06
`define AIDR_DG_GROUPS 5'h07
`define AIDR_DG_CH0 5'h08
`define AIDR_DG_CH4 5'h0c
`define AIDR_DG_TS0 5'h10
`define AIDR_DG_LEN 5'h14
// Constant field values
`define AIDR_MODCLASS 4'h5
`define AIDR_CHINFO_BIT 4
`define AIDR_CHKIND_AI 7'h71
`define AIDR_DIAG_BITS_PER_CHANNEL_VAL 8'h08
`define AIDR_CHANNEL_COUNT_VAL 8'h04
// Summary byte bits
`define AIDR_SUM_MODFAIL 0
`define AIDR_SUM_INTERR 1
`define AIDR_SUM_EXTERR 2
`define AIDR_SUM_CHANNEL_GROUP_FAULTS 3
`define AIDR_SUM_AUX 4
`define AIDR_SUM_PARAM 7
// Internal flag bits
`define AIDR_INT_BUFOVF 3
`define AIDR_INT_COMM 4
`define AIDR_INT_IRQLOST 6
// Channel detail bits
`define AIDR_CH_PARAM 0
`define AIDR_CH_IRQLOST 5
`define AIDR_CH_UNDER 6
`define AIDR_CH_OVER 7
`endif

// ### aidr_pkg.sv
// Types shared by the diagnostic record block
package aidr_pkg;
    typedef struct packed {
        logic module_fail;
        logic internal_err;
        logic external_err;
        logic aux_missing;
        logic param_err;
        logic diag_buf_ovf;
        logic comm_err;
        logic irq_lost;
    } aidr_mod_ev_t;
    typedef struct packed {
        logic param_err;
        logic irq_lost;
        logic underflow;
        logic overflow;
    } aidr_ch_ev_t;
endpackage : aidr_pkg

// ### aidr_diag_record.sv
// Diagnostic record and process input image of a four-channel analog input module
`timescale 1ns/1ns
`include "aidr_params.svh"
module aidr_diag_record
    import aidr_pkg::*;
#(
    parameter int TICK_CYC = `AIDR_TICK_CYC
) (
    input wire logic mclk, // 20 MHz clock
    input wire logic resetn, // Synchronous reset, active low
    input aidr_mod_ev_t mod_ev, // Module-level fault levels
    input aidr_ch_ev_t [3:0] ch_ev, // Per-channel fault levels
    input wire logic [3:0][15:0] ch_value, // Converted values
    input wire logic [2:0] in_addr, // Input area byte address
    output logic [7:0] in_rdata, // Input area byte
    input wire logic [4:0] diag_addr, // Diagnostic record byte address
    output logic [7:0] diag_rdata, // Diagnostic record byte
    input wire logic out_wr, // Output area write strobe
    input wire logic [7:0] out_wdata, // Output area data
    output logic [31:0] ticker, // Free microsecond ticker
    output logic module_fault_led, // Module error LED
    output logic [3:0] channel_fault_led // Channel error LEDs
);
    logic [15:0] value_q [4];
    logic [7:0] summary_q;
    logic [7:0] internal_q;
    logic [7:0] detail_q [4];
    logic [31:0] ticker_q;
    logic [31:0] stamp_q;
    logic [$clog2(TICK_CYC+1)-1:0] div_q;
    logic us_tick;
    logic [7:0] summary_d;
    logic [7:0] internal_d;
    logic [7:0] detail_d [4];
    logic [3:0] groups;
    logic event_rise;

    // Microsecond enable from the 20 MHz clock
    always_ff @(posedge mclk) begin
        if (!resetn || us_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign us_tick = (div_q == ($clog2(TICK_CYC+1))'(TICK_CYC - 1));

    // Wraps naturally through the 32-bit width
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ticker_q <= '0;
        end else if (us_tick) begin
            ticker_q <= ticker_q + 32'h1;
        end
    end
    assign ticker = ticker_q;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ch
            always_comb begin
                detail_d[g] = 8'h00;
                detail_d[g][`AIDR_CH_PARAM] = ch_ev[g].param_err;
                detail_d[g][`AIDR_CH_IRQLOST] = ch_ev[g].irq_lost;
                detail_d[g][`AIDR_CH_UNDER] = ch_ev[g].underflow;
                detail_d[g][`AIDR_CH_OVER] = ch_ev[g].overflow;
            end
            assign groups[g] = |detail_q[g];
            // Lit from the registered state so the LED matches what is read
            assign channel_fault_led[g] = detail_q[g][`AIDR_CH_UNDER] | detail_q[g][`AIDR_CH_OVER]
                | detail_q[g][`AIDR_CH_PARAM] | summary_q[`AIDR_SUM_PARAM];
            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    detail_q[g] <= 8'h00;
                    value_q[g] <= 16'h0000;
                end else begin
                    detail_q[g] <= detail_d[g];
                    value_q[g] <= ch_value[g];
                end
            end

            property p_value;
                @(posedge mclk) disable iff (!resetn) 1'b1 |=> value_q[g] == $past(ch_value[g]);
            endproperty
            a_value: assert property (p_value) else $error("analog value not captured");

            property p_led_off;
                @(posedge mclk) disable iff (!resetn) !ch_ev[g].param_err && !ch_ev[g].underflow
                    && !ch_ev[g].overflow && !summary_d[`AIDR_SUM_PARAM] |=> !channel_fault_led[g];
            endproperty
            a_led_off: assert property (p_led_off) else $error("channel led lit without fault");

            property p_detail_rsvd;
                @(posedge mclk) disable iff (!resetn) detail_q[g][4:1] == 4'h0;
            endproperty
            a_detail_rsvd: assert property (p_detail_rsvd) else $error("reserved detail bits set");

            property p_group_clear;
                @(posedge mclk) disable iff (!resetn) !(|detail_d[g]) |=> !groups[g];
            endproperty
            a_group_clear: assert property (p_group_clear) else $error("group fault without detail");
        end
    endgenerate

    always_comb begin
        summary_d = 8'h00;
        summary_d[`AIDR_SUM_MODFAIL] = mod_ev.module_fail;
        summary_d[`AIDR_SUM_INTERR] = mod_ev.internal_err | mod_ev.diag_buf_ovf | mod_ev.comm_err;
        summary_d[`AIDR_SUM_EXTERR] = mod_ev.external_err | mod_ev.aux_missing;
        summary_d[`AIDR_SUM_CHANNEL_GROUP_FAULTS] = |groups;
        summary_d[`AIDR_SUM_AUX] = mod_ev.aux_missing;
        summary_d[`AIDR_SUM_PARAM] = mod_ev.param_err | ch_ev[0].param_err | ch_ev[1].param_err
            | ch_ev[2].param_err | ch_ev[3].param_err;
        internal_d = 8'h00;
        internal_d[`AIDR_INT_BUFOVF] = mod_ev.diag_buf_ovf;
        internal_d[`AIDR_INT_COMM] = mod_ev.comm_err;
        internal_d[`AIDR_INT_IRQLOST] = mod_ev.irq_lost;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            summary_q <= 8'h00;
            internal_q <= 8'h00;
        end else begin
            summary_q <= summary_d;
            internal_q <= internal_d;
        end
    end

    // Stamp on a new flag becoming set; a flag clearing leaves the stamp alone.
    // Channel summary bit trails its detail bit by a cycle, so it must not restamp.
    assign event_rise = (|(summary_d & ~summary_q & ~(8'h01 << `AIDR_SUM_CHANNEL_GROUP_FAULTS))) | (|(internal_d & ~internal_q))
        | (|(detail_d[0] & ~detail_q[0])) | (|(detail_d[1] & ~detail_q[1]))
        | (|(detail_d[2] & ~detail_q[2])) | (|(detail_d[3] & ~detail_q[3]));

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            stamp_q <= 32'h0;
        end else if (event_rise) begin
            stamp_q <= ticker_q;
        end
    end

    assign module_fault_led = |summary_q;

    always_comb begin
        unique case (in_addr[2:1])
            2'd0: in_rdata = in_addr[0] ? value_q[0][15:8] : value_q[0][7:0];
            2'd1: in_rdata = in_addr[0] ? value_q[1][15:8] : value_q[1][7:0];
            2'd2: in_rdata = in_addr[0] ? value_q[2][15:8] : value_q[2][7:0];
            default: in_rdata = in_addr[0] ? value_q[3][15:8] : value_q[3][7:0];
        endcase
    end

    always_comb begin
        diag_rdata = 8'h00;
        unique case (diag_addr)
            `AIDR_DG_SUMMARY: diag_rdata = summary_q;
            `AIDR_DG_MODINFO: diag_rdata = {3'b000, 1'b1, `AIDR_MODCLASS};
            `AIDR_DG_INTERNAL: diag_rdata = internal_q;
            `AIDR_DG_CHKIND: diag_rdata = {1'b0, `AIDR_CHKIND_AI};
            `AIDR_DG_DIAG_BITS_PER_CHANNEL: diag_rdata = `AIDR_DIAG_BITS_PER_CHANNEL_VAL;
            `AIDR_DG_CHANNEL_COUNT: diag_rdata = `AIDR_CHANNEL_COUNT_VAL;
            `AIDR_DG_GROUPS: diag_rdata = {4'h0, groups};
            5'h08: diag_rdata = detail_q[0];
            5'h09: diag_rdata = detail_q[1];
            5'h0a: diag_rdata = detail_q[2];
            5'h0b: diag_rdata = detail_q[3];
            5'h10: diag_rdata = stamp_q[7:0];
            5'h11: diag_rdata = stamp_q[15:8];
            5'h12: diag_rdata = stamp_q[23:16];
            5'h13: diag_rdata = stamp_q[31:24];
            // Reserved byte and channels 4 to 7 stay zero
            default: diag_rdata = 8'h00;
        endcase
    end

    // Output area: strobe and data are accepted and dropped
    logic unused_out;
    assign unused_out = out_wr & (|out_wdata);

    property p_tick_wrap;
        @(posedge mclk) disable iff (!resetn) us_tick && ticker_q == 32'hffffffff |=> ticker_q == 32'h0;
    endproperty
    a_tick_wrap: assert property (p_tick_wrap) else $error("ticker did not wrap");
    property p_tick_hold;
        @(posedge mclk) disable iff (!resetn) !us_tick |=> $stable(ticker_q);
    endproperty
    a_tick_hold: assert property (p_tick_hold) else $error("ticker moved between ticks");

    // Cycles since the ticker last moved, counted apart from the divider
    logic [31:0] ticker_seen_q;
    logic [15:0] tick_gap_q;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ticker_seen_q <= 32'h0;
            tick_gap_q <= 16'h0000;
        end else begin
            ticker_seen_q <= ticker_q;
            tick_gap_q <= (ticker_q != ticker_seen_q) ? 16'h0001 : tick_gap_q + 16'h0001;
        end
    end

    property p_tick_rate;
        @(posedge mclk) disable iff (!resetn) ticker_q != ticker_seen_q |-> tick_gap_q == 16'(TICK_CYC);
    endproperty
    a_tick_rate: assert property (p_tick_rate) else $error("tick period wrong");
    property p_tick_gap;
        @(posedge mclk) disable iff (!resetn) ticker_q == ticker_seen_q |-> tick_gap_q < 16'(TICK_CYC);
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick overdue");
    property p_tick_step;
        @(posedge mclk) disable iff (!resetn) us_tick |=> ticker_q == $past(ticker_q) + 32'h1;
    endproperty
    a_tick_step: assert property (p_tick_step) else $error("ticker step wrong");
    property p_stamp;
        @(posedge mclk) disable iff (!resetn) event_rise |=> stamp_q == $past(ticker_q);
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp not captured");
    property p_over;
        @(posedge mclk) disable iff (!resetn) ch_ev[0].overflow |=> detail_q[0][7] && channel_fault_led[0];
    endproperty
    a_over: assert property (p_over) else $error("overflow not flagged");
    property p_under;
        @(posedge mclk) disable iff (!resetn) ch_ev[2].underflow |=> detail_q[2][6] && channel_fault_led[2];
    endproperty
    a_under: assert property (p_under) else $error("underflow not flagged");
    property p_group;
        @(posedge mclk) disable iff (!resetn) ch_ev[1].irq_lost |=> groups[1] ##1 summary_q[3];
    endproperty
    a_group: assert property (p_group) else $error("group fault missing");
    property p_modinfo;
        @(posedge mclk) disable iff (!resetn) diag_addr == 5'h01 |-> diag_rdata == 8'h15;
    endproperty
    a_modinfo: assert property (p_modinfo) else $error("module info wrong");
    property p_rsvd;
        @(posedge mclk) disable iff (!resetn) diag_addr >= 5'h0c && diag_addr < 5'h10 |-> diag_rdata == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved detail byte nonzero");
    property p_aux;
        @(posedge mclk) disable iff (!resetn) mod_ev.aux_missing |=> summary_q[4] && summary_q[2] && !summary_q[6];
    endproperty
    a_aux: assert property (p_aux) else $error("aux supply flag wrong");

    property p_modfail;
        @(posedge mclk) disable iff (!resetn) mod_ev.module_fail |=> summary_q[`AIDR_SUM_MODFAIL];
    endproperty
    a_modfail: assert property (p_modfail) else $error("module failure not flagged");
    property p_interr;
        @(posedge mclk) disable iff (!resetn) mod_ev.internal_err |=> summary_q[`AIDR_SUM_INTERR];
    endproperty
    a_interr: assert property (p_interr) else $error("internal error not flagged");
    property p_exterr;
        @(posedge mclk) disable iff (!resetn) mod_ev.external_err |=> summary_q[`AIDR_SUM_EXTERR];
    endproperty
    a_exterr: assert property (p_exterr) else $error("external error not flagged");
    property p_channel_group_faults;
        @(posedge mclk) disable iff (!resetn) |groups |=> summary_q[`AIDR_SUM_CHANNEL_GROUP_FAULTS];
    endproperty
    a_channel_group_faults: assert property (p_channel_group_faults) else $error("channel error not summarised");
    property p_sum_rsvd;
        @(posedge mclk) disable iff (!resetn) summary_q[6:5] == 2'b00;
    endproperty
    a_sum_rsvd: assert property (p_sum_rsvd) else $error("reserved summary bits set");
    property p_param;
        @(posedge mclk) disable iff (!resetn) mod_ev.param_err
            |=> summary_q[`AIDR_SUM_PARAM] && channel_fault_led == 4'hf;
    endproperty
    a_param: assert property (p_param) else $error("parameter error not flagged");

    property p_bufovf;
        @(posedge mclk) disable iff (!resetn) mod_ev.diag_buf_ovf |=> internal_q[`AIDR_INT_BUFOVF];
    endproperty
    a_bufovf: assert property (p_bufovf) else $error("buffer overflow not flagged");
    property p_comm;
        @(posedge mclk) disable iff (!resetn) mod_ev.comm_err |=> internal_q[`AIDR_INT_COMM];
    endproperty
    a_comm: assert property (p_comm) else $error("communication error not flagged");
    property p_irqlost;
        @(posedge mclk) disable iff (!resetn) mod_ev.irq_lost |=> internal_q[`AIDR_INT_IRQLOST];
    endproperty
    a_irqlost: assert property (p_irqlost) else $error("lost interrupt not flagged");
    property p_int_rsvd;
        @(posedge mclk) disable iff (!resetn) internal_q[2:0] == 3'b000 && !internal_q[5] && !internal_q[7];
    endproperty
    a_int_rsvd: assert property (p_int_rsvd) else $error("reserved internal bits set");

    property p_chkind;
        @(posedge mclk) disable iff (!resetn) diag_addr == 5'h04 |-> diag_rdata == 8'h71;
    endproperty
    a_chkind: assert property (p_chkind) else $error("channel kind wrong");
    property p_diag_bits_per_channel;
        @(posedge mclk) disable iff (!resetn) diag_addr == 5'h05 |-> diag_rdata == 8'h08;
    endproperty
    a_diag_bits_per_channel: assert property (p_diag_bits_per_channel) else $error("bits per channel wrong");
    property p_channel_count;
        @(posedge mclk) disable iff (!resetn) diag_addr == 5'h06 |-> diag_rdata == 8'h04;
    endproperty
    a_channel_count: assert property (p_channel_count) else $error("channel count wrong");
    property p_grp_rsvd;
        @(posedge mclk) disable iff (!resetn) diag_addr == 5'h07 |-> diag_rdata[7:4] == 4'h0;
    endproperty
    a_grp_rsvd: assert property (p_grp_rsvd) else $error("reserved group bits set");

    property p_ch_param;
        @(posedge mclk) disable iff (!resetn) ch_ev[3].param_err
            |=> detail_q[3][`AIDR_CH_PARAM] && summary_q[`AIDR_SUM_PARAM];
    endproperty
    a_ch_param: assert property (p_ch_param) else $error("channel parameter error not flagged");
    property p_ch_irq;
        @(posedge mclk) disable iff (!resetn) ch_ev[2].irq_lost |=> detail_q[2][`AIDR_CH_IRQLOST];
    endproperty
    a_ch_irq: assert property (p_ch_irq) else $error("channel lost interrupt not flagged");

    property p_in_lo0;
        @(posedge mclk) disable iff (!resetn) in_addr == 3'h0 |-> in_rdata == value_q[0][7:0];
    endproperty
    a_in_lo0: assert property (p_in_lo0) else $error("input byte 0 wrong");
    property p_in_hi;
        @(posedge mclk) disable iff (!resetn) in_addr == 3'h5 |-> in_rdata == value_q[2][15:8];
    endproperty
    a_in_hi: assert property (p_in_hi) else $error("input byte 5 wrong");
    property p_in_lo;
        @(posedge mclk) disable iff (!resetn) in_addr == 3'h6 |-> in_rdata == value_q[3][7:0];
    endproperty
    a_in_lo: assert property (p_in_lo) else $error("input byte 6 wrong");

    property p_stamp_hold;
        @(posedge mclk) disable iff (!resetn) !event_rise |=> $stable(stamp_q);
    endproperty
    a_stamp_hold: assert property (p_stamp_hold) else $error("stamp moved without event");
    property p_ts_low;
        @(posedge mclk) disable iff (!resetn) diag_addr == 5'h10 |-> diag_rdata == stamp_q[7:0];
    endproperty
    a_ts_low: assert property (p_ts_low) else $error("stamp low byte wrong");
    property p_ts_mid;
        @(posedge mclk) disable iff (!resetn) diag_addr == 5'h11 |-> diag_rdata == stamp_q[15:8];
    endproperty
    a_ts_mid: assert property (p_ts_mid) else $error("stamp second byte wrong");
    property p_ts_top;
        @(posedge mclk) disable iff (!resetn) diag_addr == 5'h13 |-> diag_rdata == stamp_q[31:24];
    endproperty
    a_ts_top: assert property (p_ts_top) else $error("stamp top byte wrong");
    property p_rsvd_byte;
        @(posedge mclk) disable iff (!resetn) diag_addr == 5'h02 || diag_addr >= 5'h14 |-> diag_rdata == 8'h00;
    endproperty
    a_rsvd_byte: assert property (p_rsvd_byte) else $error("reserved record byte nonzero");

    c_stamp: cover property (@(posedge mclk) disable iff (!resetn) event_rise);
    c_led: cover property (@(posedge mclk) disable iff (!resetn) channel_fault_led[3]);
    c_read_ts: cover property (@(posedge mclk) disable iff (!resetn) diag_addr == 5'h10 && stamp_q != 32'h0);
    c_out_write: cover property (@(posedge mclk) disable iff (!resetn) out_wr);
    c_led_all: cover property (@(posedge mclk) disable iff (!resetn) channel_fault_led == 4'hf);
endmodule : aidr_diag_record

// ### aidr_host_model.sv
// Head station model reading the record and writing the unused output area
`timescale 1ns/1ns
module aidr_host_model (
    input wire logic mclk, // Backplane clock
    output logic [2:0] in_addr, // Input area byte address
    input wire logic [7:0] in_rdata, // Input area byte
    output logic [4:0] diag_addr, // Record byte address
    input wire logic [7:0] diag_rdata, // Record byte
    output logic out_wr, // Output area write strobe
    output logic [7:0] out_wdata // Output area data
);
    initial begin
        in_addr = 3'h0;
        diag_addr = 5'h00;
        out_wr = 1'b0;
        out_wdata = 8'h00;
    end
    // Device reads are combinational, so a short settle is enough
    task automatic rd_in(input logic [2:0] a, output logic [7:0] d);
        in_addr = a;
        #1;
        d = in_rdata;
    endtask : rd_in
    task automatic rd_dg(input logic [4:0] a, output logic [7:0] d);
        diag_addr = a;
        #1;
        d = diag_rdata;
    endtask : rd_dg
    // Entered at a falling edge; strobe spans one rising edge
    task automatic wr_out(input logic [7:0] v);
        out_wr = 1'b1;
        out_wdata = v;
        @(negedge mclk);
        out_wr = 1'b0;
        out_wdata = ~v; // Released data must not look valid
    endtask : wr_out
endmodule : aidr_host_model

// ### tb_top.sv
// Self-checking bench for the diagnostic record block
`timescale 1ns/1ns
module tb_top
    import aidr_pkg::*;
;
    localparam int TCYC = 2; // Short tick keeps ticker checks quick
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    aidr_mod_ev_t mod_ev = '0;
    aidr_ch_ev_t [3:0] ch_ev = '0;
    logic [3:0][15:0] ch_value = '0;
    logic [2:0] in_addr;
    logic [4:0] diag_addr;
    logic [7:0] in_rdata, diag_rdata, out_wdata, d;
    logic out_wr, module_fault_led;
    logic [31:0] ticker, t0, t1;
    logic [3:0] channel_fault_led;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    integer seed = 32'hdce72935;
    always #25 mclk = ~mclk;
    aidr_diag_record #(.TICK_CYC(TCYC)) i_dut (.mclk(mclk), .resetn(resetn), .mod_ev(mod_ev), .ch_ev(ch_ev),
        .ch_value(ch_value), .in_addr(in_addr), .in_rdata(in_rdata), .diag_addr(diag_addr),
        .diag_rdata(diag_rdata), .out_wr(out_wr), .out_wdata(out_wdata), .ticker(ticker),
        .module_fault_led(module_fault_led), .channel_fault_led(channel_fault_led));
    aidr_host_model i_host (.mclk(mclk), .in_addr(in_addr), .in_rdata(in_rdata), .diag_addr(diag_addr),
        .diag_rdata(diag_rdata), .out_wr(out_wr), .out_wdata(out_wdata));
    function automatic logic [7:0] det(aidr_ch_ev_t e);
        return {e.overflow, e.underflow, e.irq_lost, 4'h0, e.param_err};
    endfunction : det
    function automatic logic [7:0] grp();
        return {4'h0, |det(ch_ev[3]), |det(ch_ev[2]), |det(ch_ev[1]), |det(ch_ev[0])};
    endfunction : grp
    function automatic logic [7:0] summ();
        logic cp;
        cp = ch_ev[0].param_err | ch_ev[1].param_err | ch_ev[2].param_err | ch_ev[3].param_err;
        return {mod_ev.param_err | cp, 2'h0, mod_ev.aux_missing, |grp(), mod_ev.external_err | mod_ev.aux_missing,
            mod_ev.internal_err | mod_ev.diag_buf_ovf | mod_ev.comm_err, mod_ev.module_fail};
    endfunction : summ
    function automatic logic [7:0] rec(logic [4:0] a);
        case (a)
            5'h00: return summ();
            5'h01: return 8'h15;
            5'h03: return {1'b0, mod_ev.irq_lost, 1'b0, mod_ev.comm_err, mod_ev.diag_buf_ovf, 3'h0};
            5'h04: return 8'h71;
            5'h05: return 8'h08;
            5'h06: return 8'h04;
            5'h07: return grp();
            5'h08, 5'h09, 5'h0a, 5'h0b: return det(ch_ev[a[1:0]]);
            default: return 8'h00;
        endcase
    endfunction : rec
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic stamp(output logic [31:0] v);
        for (int b = 0; b < 4; b++) begin
            i_host.rd_dg(5'(16 + b), d);
            v[8 * b +: 8] = d;
        end
    endtask : stamp
    // Read-back of every byte but the stamp bytes 16 to 19; inputs must stay still while it runs
    task automatic sweep();
        logic [3:0] cl;
        logic [7:0] s;
        for (int a = 0; a < 32; a++) begin
            if (a < 16 || a > 19) begin
                i_host.rd_dg(5'(a), d);
                chk(d, rec(5'(a)), "record byte");
            end
        end
        for (int a = 0; a < 8; a++) begin
            i_host.rd_in(3'(a), d);
            chk(d, ch_value[a / 2][8 * (a % 2) +: 8], "input byte");
        end
        s = summ();
        for (int n = 0; n < 4; n++) cl[n] = ch_ev[n].overflow | ch_ev[n].underflow | ch_ev[n].param_err | s[7];
        chk(channel_fault_led, cl, "channel led");
        chk(module_fault_led, |summ(), "module led");
    endtask : sweep
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        repeat (10) @(negedge mclk);
        resetn = 1'b1;
        chk(ticker, 32'h0, "ticker start");
        sweep();
        @(negedge mclk);
        t0 = ticker;
        repeat (7 * TCYC) @(negedge mclk);
        chk(ticker, t0 + 32'd7, "ticker rate");
        repeat (40) begin
            @(negedge mclk);
            mod_ev = aidr_mod_ev_t'(8'($random(seed)));
            ch_ev = 16'($random(seed));
            ch_value = {$random(seed), $random(seed)};
            i_host.wr_out(8'($random(seed)));
            @(negedge mclk);
            sweep();
        end
        @(negedge mclk);
        mod_ev = '0;
        ch_ev = '0;
        repeat (3) @(negedge mclk);
        t0 = ticker;
        ch_ev[2].underflow = 1'b1;
        @(negedge mclk);
        i_host.rd_dg(5'h0a, d);
        chk(d, 8'h40, "underflow detail");
        chk(channel_fault_led, 4'h4, "led after event");
        stamp(t1);
        chk(t1, t0, "stamp");
        @(negedge mclk);
        i_host.rd_dg(5'h00, d);
        chk(d, 8'h08, "summary channel bit");
        ch_ev = '0;
        repeat (3 * TCYC) @(negedge mclk);
        stamp(t1);
        chk(t1, t0, "stamp held");
        @(negedge mclk);
        mod_ev = aidr_mod_ev_t'(8'hff);
        resetn = 1'b0;
        repeat (2) @(negedge mclk);
        chk(ticker, 32'h0, "ticker in reset");
        chk(module_fault_led, 1'b0, "led in reset");
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
        sweep();
        test_done();
    end
endmodule : tb_top
